// ===== shared/rss_pkg.sv
// constants, types and opcode layout of the radio strobe sequencer
// assumes a single 200 MHz clock shared by host port, timer and radio
package rss_pkg;

    // clocking: the sequencer steps at 8 MHz, derived from ref_clk
    localparam int unsigned CLK_HZ   = 200_000_000;
    localparam int unsigned SEQ_HZ   = 8_000_000;
    localparam int unsigned SEQ_DIV  = CLK_HZ / SEQ_HZ;
    localparam logic [4:0]  DIV_LAST = 5'(SEQ_DIV - 1);

    // instruction memory
    localparam int          MEM_DEPTH = 24;
    localparam logic [5:0]  LAST_LOC  = 6'h17;
    localparam logic [4:0]  WPTR_RST  = 5'h00;
    localparam logic [4:0]  PC_RST    = 5'h00;

    // reset values of the data registers and the countdown no-decrement value
    localparam logic [7:0]  X_RST     = 8'h00;
    localparam logic [7:0]  Y_RST     = 8'h00;
    localparam logic [7:0]  Z_RST     = 8'h00;
    localparam logic [7:0]  T_RST     = 8'hFF;
    localparam logic [7:0]  CD_NO_DEC = 8'hFF;

    // opcodes
    localparam logic [7:0]  NO_OP_STROBE_OP     = 8'hC0;
    localparam logic [7:0]  OP_CMP_WAIT = 8'hB8;
    localparam logic [7:0]  OP_INT      = 8'hB9;
    localparam logic [7:0]  OP_MARK     = 8'hBA;
    localparam logic [7:0]  OP_OVERFLOW_WAIT_X    = 8'hBB;
    localparam logic [7:0]  OP_RAND     = 8'hBC;
    localparam logic [7:0]  OP_YUP      = 8'hBD;
    localparam logic [7:0]  OP_YDN      = 8'hBE;
    localparam logic [7:0]  OP_ZDN      = 8'hBF;
    localparam logic [2:0]  GRP_WAIT    = 3'h4;
    localparam logic [2:0]  GRP_STROBE_CODE    = 3'h6;
    localparam logic [2:0]  GRP_IMM     = 3'h7;
    localparam logic [3:0]  GRP_LOOP    = 4'hA;
    localparam logic [4:0]  GRP_SAT     = 5'h16;
    localparam logic [5:0]  WAIT_ZERO   = 6'h20;

    // no-op strobe code, and strobe codes that also steer the sequencer
    localparam logic [4:0]  STROBE_CODE_NOP    = 5'h00;
    localparam logic [4:0]  STROBE_CODE_LAUNCH = 5'h1E;
    localparam logic [4:0]  STROBE_CODE_IHALT  = 5'h1F;
    localparam logic [4:0]  STROBE_CODE_PHALT  = 5'h1F;

    // wait kinds
    localparam logic [1:0]  WK_OVF = 2'h0;
    localparam logic [1:0]  WK_X   = 2'h1;
    localparam logic [1:0]  WK_CMP = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN  = 3'b010,
        ST_WAIT = 3'b100
    } rss_state_t;

    typedef struct packed {
        logic       imm;
        logic [4:0] code;
    } rss_strobe_t;

endpackage

// ===== verilog/rss_tick_div.sv
// divider making the one-cycle 8 MHz step enable from ref_clk
// assumes rst_sync_n is already synchronised to ref_clk
`timescale 1ns/100ps
module rss_tick_div import rss_pkg::*; (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_sync_n,
    // step enable
    output logic      tick
);
    logic [4:0] cnt_q;

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cnt_q <= 5'h00;
        end else if (cnt_q == DIV_LAST) begin
            cnt_q <= 5'h00;
        end else begin
            cnt_q <= cnt_q + 5'h01;
        end
    end

    assign tick = (cnt_q == DIV_LAST);

    chk_tick_period: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
        tick |=> !tick ##24 tick)
        else $error("step enable not at 8 MHz");

endmodule // rss_tick_div

// ===== verilog/rss_seq.sv
// radio strobe sequencer: instruction memory, program engine, data registers
// assumes timer, random source and condition inputs come from ref_clk logic
// Functional notes
// - programs live in a 24-byte memory, one byte per instruction.
// - each load stores at write pointer then advances; sticks at last entry.
// - write pointer returns to 0 on immediate halt or executed program halt.
// - reset fills every memory entry with the no-op strobe 0xC0.
// - countdown decrements per timer overflow while running; zero halts with halt flag.
// - countdown held at 0xFF is never decremented.
// - immediate launch strobe starts execution at location 0.
// - end of memory, countdown zero, halts, or far skip stop execution.
// - the sequencer steps at 8 MHz.
// - overflow waits raise wait-done on completion; X wait with X zero is instant.
// - raise-interrupt instruction pulses the program interrupt flag.
// - immediate strobe runs first; stored instruction waits until it is done.
// - port read gives current instruction while running, or 0xC0 when idle or during immediate strobes.
// - random load fills low Y bits of X, all 8 when Y is zero; repeated loads reuse one value.
// - end-of-program halt keeps memory; program or immediate halt clears it.
// - a wait between X update and X read makes overflows decrement X.
// - undefined opcodes act as the no-op strobe.
// - bit 7 clear is a skip of S when C xor N.
// - top bits 100 wait W overflows, 32 when W is zero.
// - mark records loop start; 1010 repeats back when C xor N.
// - 110 are stored strobes, 111 are immediate strobes.
// - timer overflow events time the overflow and X waits and the countdown; compare waits end on tmr_match.
// - Y and Z are 8 bits; Y wraps on increment and decrement, Z wraps on decrement.
`timescale 1ns/100ps
module rss_seq import rss_pkg::*; (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // strobe instruction port
    input  wire logic        sip_wr,
    input  wire logic [7:0]  sip_wdata,
    output logic [7:0]       sip_rdata,
    // host access to data registers
    input  wire logic        x_wr,
    input  wire logic        y_wr,
    input  wire logic        z_wr,
    input  wire logic        t_wr,
    input  wire logic [7:0]  reg_wdata,
    output logic [7:0]       loop_count_x,
    output logic [7:0]       param_y,
    output logic [7:0]       param_z,
    output logic [7:0]       overflow_countdown,
    // timer, conditions, random source
    input  wire logic        tmr_ovf,
    input  wire logic        tmr_match,
    input  wire logic [7:0]  cond_in,
    input  wire logic [7:0]  rng_dout,
    // radio strobes
    output logic             strobe_vld,
    output rss_strobe_t      strobe_out,
    // status
    output logic             running,
    output logic             halt_flag,
    output logic             wait_done_flag,
    output logic             prog_irq_flag
);
    ////////////////////////////////////////////////////////////////////////
    logic [1:0]  rst_ff_q;
    logic        rst_sync_n;
    logic        tick;
    rss_state_t  st_q, st_d;
    logic [4:0]  pc_q, pc_d, loop_q, loop_d, wptr_q;
    logic [5:0]  wcnt_q, wcnt_d;
    logic [1:0]  wk_q, wk_d;
    logic [7:0]  x_q, x_d, y_q, y_d, z_q, t_q, rng_q, rdata_q;
    logic [7:0]  mem_q [MEM_DEPTH];
    logic        tick_pend_q, dirty_q, armed_q;
    logic        strobe_code_vld_q, strobe_code_vld_d, halt_q, halt_d, wdone_q, wdone_d, int_q, int_d;
    logic        mem_clr, z_dn;
    rss_strobe_t strobe_code_q, strobe_code_d;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_ff_q <= 2'b00;
        end else begin
            rst_ff_q <= {rst_ff_q[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_ff_q[1];

    rss_tick_div u_div (
        .ref_clk    (ref_clk),
        .rst_sync_n (rst_sync_n),
        .tick       (tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // decode
    wire        host_imm   = sip_wr && (sip_wdata[7:5] == GRP_IMM);
    wire        host_load  = sip_wr && !host_imm;
    wire        imm_launch = host_imm && (sip_wdata[4:0] == STROBE_CODE_LAUNCH);
    wire        imm_halt   = host_imm && (sip_wdata[4:0] == STROBE_CODE_IHALT);
    wire        is_run     = (st_q != ST_IDLE);
    // a pending step waits out any immediate strobe in the same cycle
    wire        step       = (st_q == ST_RUN) && tick_pend_q && !host_imm;
    wire [7:0]  op         = mem_q[pc_q];
    wire        is_skip    = !op[7];
    wire        is_wait    = (op[7:5] == GRP_WAIT);
    wire        is_loop    = (op[7:4] == GRP_LOOP);
    wire        is_sat     = (op[7:3] == GRP_SAT);
    wire        is_strobe_code    = (op[7:5] == GRP_STROBE_CODE);
    wire        is_imm_op  = (op[7:5] == GRP_IMM);
    wire        cond_ok    = cond_in[op[2:0]] ^ op[3];
    wire        x_reader   = is_skip || is_loop || (op == OP_OVERFLOW_WAIT_X);
    wire [5:0]  next_seq   = {1'b0, pc_q} + 6'h01;
    wire [5:0]  skip_tgt   = next_seq + {3'b000, op[6:4]};
    wire [5:0]  pc_tgt     = (is_skip && cond_ok) ? skip_tgt :
                             (is_loop && cond_ok) ? {1'b0, loop_q} : next_seq;
    wire        past_end   = (pc_tgt > LAST_LOC);
    wire [7:0]  y_inc      = y_q + 8'h01;
    wire [7:0]  sat_m      = {5'b00000, op[2:0]};
    wire [7:0]  y_sat      = ((y_q == 8'hFF) || (y_inc >= sat_m)) ? sat_m : y_inc;
    wire [7:0]  rand_mask  = ((y_q == 8'h00) || (y_q > 8'h08)) ? 8'hFF :
                             ~(8'hFF << y_q[3:0]);
    wire        cd_dec     = is_run && tmr_ovf && (t_q != CD_NO_DEC) && (t_q != 8'h00);
    wire        cd_hit     = is_run && (t_q == 8'h00);
    wire        wait_fin   = (wk_q == WK_CMP) ? tmr_match :
                             (wk_q == WK_X) ? (x_q == 8'h00) ||
                             (tmr_ovf && (x_q == 8'h01)) :
                             (tmr_ovf && (wcnt_q == 6'h01));
    wire        x_ovf_dec  = tmr_ovf && (x_q != 8'h00) &&
                             (armed_q || ((st_q == ST_WAIT) && (wk_q == WK_X)));
    wire        prog_halt  = step && is_strobe_code && (op[4:0] == STROBE_CODE_PHALT);

    ////////////////////////////////////////////////////////////////////////
    // program engine
    always_comb begin
        st_d       = st_q;
        pc_d       = pc_q;
        loop_d     = loop_q;
        wcnt_d     = wcnt_q;
        wk_d       = wk_q;
        x_d        = x_ovf_dec ? x_q - 8'h01 : x_q;
        y_d        = y_q;
        z_dn       = 1'b0;
        strobe_code_vld_d = 1'b0;
        strobe_code_d     = '{imm: 1'b0, code: STROBE_CODE_NOP};
        halt_d     = 1'b0;
        wdone_d    = 1'b0;
        int_d      = 1'b0;
        mem_clr    = imm_halt || prog_halt;
        if (host_imm) begin
            strobe_code_vld_d = 1'b1;
            strobe_code_d     = '{imm: 1'b1, code: sip_wdata[4:0]};
        end
        unique case (st_q)
            ST_IDLE: begin
                if (imm_launch) begin
                    st_d = ST_RUN;
                    pc_d = PC_RST;
                end
            end
            ST_RUN: begin
                if (step) begin
                    pc_d = pc_tgt[4:0];
                    if (past_end) begin
                        st_d   = ST_IDLE;
                        halt_d = 1'b1;
                    end
                    if (is_wait) begin
                        st_d   = ST_WAIT;
                        halt_d = 1'b0;
                        pc_d   = pc_q;
                        wk_d   = WK_OVF;
                        wcnt_d = (op[4:0] == 5'h00) ? WAIT_ZERO : {1'b0, op[4:0]};
                    end else if (op == OP_CMP_WAIT) begin
                        st_d   = ST_WAIT;
                        halt_d = 1'b0;
                        pc_d   = pc_q;
                        wk_d   = WK_CMP;
                    end else if (op == OP_OVERFLOW_WAIT_X) begin
                        if (x_q == 8'h00) begin
                            wdone_d = 1'b1;
                        end else begin
                            st_d   = ST_WAIT;
                            halt_d = 1'b0;
                            pc_d   = pc_q;
                            wk_d   = WK_X;
                        end
                    end
                    if (op == OP_MARK) begin
                        loop_d = next_seq[4:0];
                    end
                    if (op == OP_INT) begin
                        int_d = 1'b1;
                    end
                    if (op == OP_YUP) begin
                        y_d = y_inc;
                    end
                    if (op == OP_YDN) begin
                        y_d = y_q - 8'h01;
                    end
                    if (is_sat) begin
                        y_d = y_sat;
                    end
                    if (op == OP_ZDN) begin
                        z_dn = 1'b1;
                    end
                    if (op == OP_RAND) begin
                        x_d = rng_q & rand_mask;
                    end
                    if (is_strobe_code || is_imm_op) begin
                        strobe_code_vld_d = 1'b1;
                        strobe_code_d     = '{imm: 1'b0, code: is_strobe_code ? op[4:0] : STROBE_CODE_NOP};
                    end
                    if (prog_halt) begin
                        st_d   = ST_IDLE;
                        halt_d = 1'b1;
                    end
                end
            end
            ST_WAIT: begin
                if (wcnt_q != 6'h00 && wk_q == WK_OVF && tmr_ovf) begin
                    wcnt_d = wcnt_q - 6'h01;
                end
                if (wait_fin) begin
                    st_d    = ST_RUN;
                    wdone_d = (wk_q != WK_CMP);
                    pc_d    = next_seq[4:0];
                    if (next_seq > LAST_LOC) begin
                        st_d   = ST_IDLE;
                        halt_d = 1'b1;
                    end
                end
            end
        endcase
        if (is_run && (imm_halt || cd_hit)) begin
            st_d   = ST_IDLE;
            halt_d = 1'b1;
        end
        if (st_d == ST_IDLE && st_q != ST_IDLE) begin
            pc_d = PC_RST;
        end
        if (x_wr) begin
            x_d = reg_wdata;
        end
        if (y_wr) begin
            y_d = reg_wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            st_q   <= ST_IDLE;
            pc_q   <= PC_RST;
            loop_q <= PC_RST;
            wcnt_q <= 6'h00;
            wk_q   <= WK_OVF;
            x_q    <= X_RST;
            y_q    <= Y_RST;
        end else begin
            st_q   <= st_d;
            pc_q   <= pc_d;
            loop_q <= loop_d;
            wcnt_q <= wcnt_d;
            wk_q   <= wk_d;
            x_q    <= x_d;
            y_q    <= y_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // z, countdown, random hold, X hazard tracking, step pending
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            z_q         <= Z_RST;
            t_q         <= T_RST;
            rng_q       <= 8'h00;
            dirty_q     <= 1'b0;
            armed_q     <= 1'b0;
            tick_pend_q <= 1'b0;
        end else begin
            z_q         <= z_wr ? reg_wdata : (z_dn ? z_q - 8'h01 : z_q);
            t_q         <= t_wr ? reg_wdata : (cd_dec ? t_q - 8'h01 : t_q);
            tick_pend_q <= (tick_pend_q || tick) && !step;
            // holding the sample across a load makes back-to-back loads match
            if (step && op != OP_RAND) begin
                rng_q <= rng_dout;
            end
            if (step && x_reader) begin
                dirty_q <= 1'b0;
                armed_q <= 1'b0;
            end else if (x_wr || (step && op == OP_RAND)) begin
                dirty_q <= 1'b1;
            end else if (step && dirty_q && (is_wait || op == OP_CMP_WAIT)) begin
                armed_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // instruction memory and write pointer
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            wptr_q <= WPTR_RST;
        end else if (mem_clr) begin
            wptr_q <= WPTR_RST;
        end else if (host_load && ({1'b0, wptr_q} != LAST_LOC)) begin
            wptr_q <= wptr_q + 5'h01;
        end
    end

    for (genvar i = 0; i < MEM_DEPTH; i++) begin : g_mem
        always_ff @(posedge ref_clk or negedge rst_sync_n) begin
            if (!rst_sync_n) begin
                mem_q[i] <= NO_OP_STROBE_OP;
            end else if (mem_clr) begin
                mem_q[i] <= NO_OP_STROBE_OP;
            end else if (host_load && (wptr_q == 5'(i))) begin
                mem_q[i] <= sip_wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registered outputs
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rdata_q    <= NO_OP_STROBE_OP;
            strobe_code_vld_q <= 1'b0;
            strobe_code_q     <= '{imm: 1'b0, code: STROBE_CODE_NOP};
            halt_q     <= 1'b0;
            wdone_q    <= 1'b0;
            int_q      <= 1'b0;
        end else begin
            rdata_q    <= (is_run && !host_imm) ? op : NO_OP_STROBE_OP;
            strobe_code_vld_q <= strobe_code_vld_d;
            strobe_code_q     <= strobe_code_d;
            halt_q     <= halt_d;
            wdone_q    <= wdone_d;
            int_q      <= int_d;
        end
    end

    assign sip_rdata          = rdata_q;
    assign loop_count_x       = x_q;
    assign param_y            = y_q;
    assign param_z            = z_q;
    assign overflow_countdown = t_q;
    assign strobe_vld         = strobe_code_vld_q;
    assign strobe_out         = strobe_code_q;
    assign running            = is_run;
    assign halt_flag          = halt_q;
    assign wait_done_flag     = wdone_q;
    assign prog_irq_flag      = int_q;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_sync_n);

    chk_wptr_advance: assert property (
        host_load && !mem_clr && ({1'b0, wptr_q} != LAST_LOC) |=> wptr_q == $past(wptr_q) + 5'h01)
        else $error("write pointer did not advance");
    chk_wptr_return: assert property (
        mem_clr |=> wptr_q == WPTR_RST)
        else $error("write pointer not returned to 0");
    chk_mem_store: assert property (
        host_load && !mem_clr |=> mem_q[$past(wptr_q)] == $past(sip_wdata))
        else $error("loaded byte not stored");
    chk_cd_freeze: assert property (
        t_q == CD_NO_DEC && !t_wr |=> t_q == CD_NO_DEC)
        else $error("countdown 0xFF was decremented");
    chk_cd_zero_halt: assert property (
        cd_hit |=> !running && halt_flag)
        else $error("countdown zero did not halt");
    chk_imm_bypass: assert property (
        host_imm |=> strobe_vld && strobe_out.imm && strobe_out.code == $past(sip_wdata[4:0]))
        else $error("immediate strobe not issued first");
    chk_launch_start: assert property (
        st_q == ST_IDLE && imm_launch |=> running && pc_q == PC_RST)
        else $error("launch did not start at location 0");
    chk_read_imm: assert property (
        host_imm && is_run |=> sip_rdata == NO_OP_STROBE_OP)
        else $error("read during immediate strobe not 0xC0");
    chk_wait_flag: assert property (
        st_q == ST_WAIT && wait_fin && wk_q != WK_CMP |=> wait_done_flag)
        else $error("wait completion without wait-done flag");

endmodule // rss_seq

// ===== tb/rss_timer_model.sv
// mac timer stand-in: one overflow pulse every PERIOD cycles
// assumes the sequencer shares ref_clk with it
`timescale 1ns/100ps
module rss_timer_model #(parameter int PERIOD = 40) (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_n,
    // overflow event
    output logic      tmr_ovf
);
    int cnt_q;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q   <= 0;
            tmr_ovf <= 1'b0;
        end else begin
            cnt_q   <= (cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
            tmr_ovf <= (cnt_q == PERIOD - 1);
        end
    end
endmodule // rss_timer_model

// ===== tb/radio_strobe_sequencer_tb.sv
// bench for rss_seq: host port tasks and program scenarios
// assumes the timer model supplies overflow pulses
`timescale 1ns/100ps
module radio_strobe_sequencer_tb;
    import rss_pkg::*;
    logic        ref_clk = 1'b0, rst_n = 1'b0, sip_wr = 1'b0;
    logic        x_wr = 1'b0, y_wr = 1'b0, z_wr = 1'b0, t_wr = 1'b0;
    logic [7:0]  sip_wdata = 8'h00, reg_wdata = 8'h00, y_was;
    logic [7:0]  sip_rdata, loop_count_x, param_y, param_z, overflow_countdown;
    logic        tmr_ovf, strobe_vld, running, halt_flag, wait_done_flag, prog_irq_flag;
    rss_strobe_t strobe_out;
    int          err_total = 0, compares = 0, cyc = 0, n_halt = 0, n_wt = 0, n_irq = 0;
    logic [4:0]  imm_code = 5'h00, prog_code = 5'h00;
    always #2.5 ref_clk = ~ref_clk;
    rss_timer_model u_rss_timer_model (.ref_clk, .rst_n, .tmr_ovf);
    // compare comes true with each overflow; conditions held at 0
    rss_seq u_rss_seq (.ref_clk, .rst_n, .sip_wr, .sip_wdata, .sip_rdata, .x_wr, .y_wr, .z_wr, .t_wr,
        .reg_wdata, .loop_count_x, .param_y, .param_z, .overflow_countdown, .tmr_ovf, .tmr_match(tmr_ovf),
        .cond_in(8'h00), .rng_dout(8'hA5), .strobe_vld, .strobe_out, .running, .halt_flag,
        .wait_done_flag, .prog_irq_flag);
    always @(posedge ref_clk) begin
        cyc++;
        if (halt_flag === 1'b1) n_halt++;
        if (wait_done_flag === 1'b1) n_wt++;
        if (prog_irq_flag === 1'b1) n_irq++;
        if (strobe_vld === 1'b1 && strobe_out.imm === 1'b1) imm_code = strobe_out.code;
        if (strobe_vld === 1'b1 && strobe_out.imm === 1'b0 && strobe_out.code !== STROBE_CODE_NOP)
            prog_code = strobe_out.code;
        if (cyc == 60000) begin
            err_total++;
            conclude();
        end
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        if (err_total == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic sip(input logic [7:0] b);
        sip_wdata = b;
        sip_wr = 1'b1;
        tick(1);
        sip_wr = 1'b0;
        tick(1);
    endtask
    // sel is {x, y, z, t}
    task automatic wreg(input logic [3:0] sel, input logic [7:0] d);
        reg_wdata = d;
        {x_wr, y_wr, z_wr, t_wr} = sel;
        tick(1);
        {x_wr, y_wr, z_wr, t_wr} = 4'h0;
        tick(1);
    endtask
    task automatic settle();
        int k;
        for (k = 0; k < 8000 && running !== 1'b0; k++) tick(1);
        check("done", {7'h00, running}, 8'h00);
        tick(2);
    endtask
    task automatic run();
        sip(8'hFE);
        check("run", {7'h00, running}, 8'h01);
        settle();
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        tick(12);
        rst_n = 1'b1;
        tick(3);
        check("rdata", sip_rdata, NO_OP_STROBE_OP);
        check("cd", overflow_countdown, T_RST);
        sip(8'hB9);
        sip(8'hBD);
        sip(8'hC5);
        run();
        check("irq", 8'(n_irq), 8'h01);
        check("y", param_y, 8'h01);
        check("strobe_code", {3'h0, prog_code}, 8'h05);
        check("launch", {3'h0, imm_code}, {3'h0, STROBE_CODE_LAUNCH});
        check("halt", 8'(n_halt), 8'h01);
        run();
        check("rerun", param_y, 8'h02);
        sip(8'hFE);
        tick(60);
        sip(8'hFF);
        tick(4);
        check("ihalt", 8'(n_halt), 8'h03);
        check("stop", {7'h00, running}, 8'h00);
        y_was = param_y;
        run();
        check("clr", param_y, y_was);
        // host keeps loads for idle periods only
        wreg(4'h1, 8'hFF);
        sip(8'h82);
        repeat (22) sip(NO_OP_STROBE_OP);
        sip(8'hBE);
        sip(8'hBD);
        y_was = param_y;
        run();
        check("ptr", param_y, y_was + 8'h01);
        check("wt", 8'(n_wt), 8'h01);
        check("nodec", overflow_countdown, CD_NO_DEC);
        sip(8'hFF);
        wreg(4'h1, 8'h02);
        sip(8'h80);
        run();
        check("cd0", overflow_countdown, 8'h00);
        check("cdwt", 8'(n_wt), 8'h01);
        check("cdhalt", 8'(n_halt), 8'h06);
        sip(8'hFF);
        wreg(4'h4, 8'h00);
        wreg(4'h2, 8'h00);
        wreg(4'h8, 8'h3C);
        // countdown was left at zero, which would halt the launch at once
        wreg(4'h1, 8'hFF);
        sip(8'h18);
        sip(8'hBD);
        sip(8'hBE);
        sip(8'hBF);
        run();
        check("skip", param_y, 8'hFF);
        check("z", param_z, 8'hFF);
        check("x", loop_count_x, 8'h3C);
        sip(8'hFF);
        wreg(4'h4, 8'h04);
        sip(OP_CMP_WAIT);
        sip(OP_RAND);
        sip(8'hFE);
        check("rd", sip_rdata, OP_CMP_WAIT);
        settle();
        check("rand", loop_count_x, 8'h05);
        check("evwt", 8'(n_wt), 8'h01);
        conclude();
    end
endmodule // radio_strobe_sequencer_tb
